// ==== hw/event_status.sv ====
// Sticky event status, read-to-clear, with a mask and one level interrupt.
// Assumes single-cycle event pulses and a one-cycle read strobe.
`timescale 1ns/1ps
module event_status (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] event_i,
    input wire logic rd_clear_i,
    input wire logic mask_wr_i,
    input wire logic [3:0] wdata_i,
    output logic [3:0] status_o,
    output logic [3:0] mask_o,
    output logic irq_o
);

    typedef struct packed {
        logic [3:0] status;
        logic [3:0] mask;
    } state_type;

    state_type q;
    state_type d;

    // Clear on read, but an event in that same cycle survives
    always_comb begin
        d = q;
        d.status = (rd_clear_i ? 4'h0 : q.status) | event_i;
        if (mask_wr_i) begin
            d.mask = wdata_i;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign status_o = q.status;
    assign mask_o = q.mask;
    assign irq_o = |(q.status & q.mask);

endmodule // event_status

// ==== hw/irq_flags_pkg.sv ====
// Constants shared by the timer match interrupt flag block.
// Assumes one 40 MHz clock and an 8-bit register port with one-cycle strobes.
package irq_flags_pkg;

    // ************************************************************
    // Bus widths and counts
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned TIMER_COUNT = 2;
    localparam int unsigned EVENT_COUNT = 4;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] TIMER0_CTRL_ADDR = 8'h00;
    localparam logic [7:0] TIMER1_CTRL_ADDR = 8'h01;
    localparam logic [7:0] MULTIFUNC_CTRL_ADDR = 8'h02;
    localparam logic [7:0] EVENT_STATUS_ADDR = 8'h03;
    localparam logic [7:0] EVENT_MASK_ADDR = 8'h04;

    // ************************************************************
    // Field positions of a timer match register
    // ************************************************************
    localparam int unsigned CMP_A_FLAG_BIT = 5;
    localparam int unsigned CMP_P_FLAG_BIT = 4;
    localparam int unsigned CMP_A_EN_BIT = 1;
    localparam int unsigned CMP_P_EN_BIT = 0;

    // ************************************************************
    // Field positions of the multi-function register
    // ************************************************************
    localparam int unsigned MF0_FLAG_BIT = 5;
    localparam int unsigned MF1_FLAG_BIT = 6;
    localparam int unsigned MF0_EN_BIT = 1;
    localparam int unsigned MF1_EN_BIT = 2;

    // ************************************************************
    // Implemented bits and reset values
    // ************************************************************
    localparam logic [7:0] TIMER_IMPL_MASK = 8'h33;
    localparam logic [7:0] MULTIFUNC_IMPL_MASK = 8'h66;
    localparam logic [7:0] EVENT_IMPL_MASK = 8'h0f;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

// ==== hw/timer_match_irq_flags.sv ====
// Timer comparator match interrupt flags and enables, multi-function requests.
// Assumes synchronous match pulses and a one-cycle strobe register port.
//
// Function
// - Timer 0 comparator A match sets bit 5 of its match register.
// - Timer 0 comparator P match sets bit 4 of its match register.
// - Bit 1 of the timer 0 register enables the comparator A interrupt.
// - Timer 1 comparator A match sets bit 5 of its match register.
// - Timer 1 comparator P match sets bit 4 of its match register.
// - Bit 1 of the timer 1 register enables the comparator A interrupt.
// - Bits 7-6 and 3-2 of both match registers read zero, ignore writes.
// - A multi-function 0 request flag and enable exist, 1 meaning active.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module timer_match_irq_flags (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic t0_cmp_a_match_i,
    input wire logic t0_cmp_p_match_i,
    input wire logic t1_cmp_a_match_i,
    input wire logic t1_cmp_p_match_i,
    output logic multifunc0_request_o,
    output logic multifunc1_request_o,
    output logic irq_o
);

    // ************************************************************
    // State of the top level
    // ************************************************************
    typedef struct packed {
        logic [1:0] mf_flag;
        logic [1:0] mf_en;
        logic [1:0] mf_req;
        logic [7:0] rdata;
        logic irq;
    } state_type;

    state_type q;
    state_type d;

    // ************************************************************
    // Address decode
    // ************************************************************
    logic [1:0] timer_wr;
    logic mf_wr;
    logic mask_wr;
    logic status_rd;

    // Write strobes per register
    assign timer_wr[0] = wr_i && (addr_i == irq_flags_pkg::TIMER0_CTRL_ADDR);
    assign timer_wr[1] = wr_i && (addr_i == irq_flags_pkg::TIMER1_CTRL_ADDR);
    assign mf_wr = wr_i && (addr_i == irq_flags_pkg::MULTIFUNC_CTRL_ADDR);
    assign mask_wr = wr_i && (addr_i == irq_flags_pkg::EVENT_MASK_ADDR);
    // The status register clears on the read strobe itself
    assign status_rd = rd_i && (addr_i == irq_flags_pkg::EVENT_STATUS_ADDR);

    // ************************************************************
    // Timer match registers
    // ************************************************************
    logic [1:0] match_a;
    logic [1:0] match_p;
    logic [7:0] timer_rdata [2];
    logic [1:0] timer_req;

    // Gather match pulses per timer
    assign match_a = {t1_cmp_a_match_i, t0_cmp_a_match_i};
    assign match_p = {t1_cmp_p_match_i, t0_cmp_p_match_i};

    // One register instance per timer
    for (genvar t = 0; t < 2; t++) begin : gen_timer
        timer_match_regs u_regs (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .wr_en_i(timer_wr[t]),
            .wdata_i(wdata_i),
            .cmp_a_match_i(match_a[t]),
            .cmp_p_match_i(match_p[t]),
            .rdata_o(timer_rdata[t]),
            .request_o(timer_req[t])
        );
    end

    // ************************************************************
    // Event status and interrupt
    // ************************************************************
    logic [3:0] ev_status;
    logic [3:0] ev_mask;
    logic ev_irq;

    // Raw match pulses feed the sticky status, independent of enables
    event_status u_events (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .event_i({t1_cmp_p_match_i, t1_cmp_a_match_i, t0_cmp_p_match_i, t0_cmp_a_match_i}),
        .rd_clear_i(status_rd),
        .mask_wr_i(mask_wr),
        .wdata_i(wdata_i[3:0]),
        .status_o(ev_status),
        .mask_o(ev_mask),
        .irq_o(ev_irq)
    );

    // ************************************************************
    // Read views of the local registers
    // ************************************************************
    logic [7:0] mf_view;
    logic [7:0] status_view;
    logic [7:0] mask_view;

    // Multi-function register; unused bits read as zero
    always_comb begin
        mf_view = irq_flags_pkg::READ_ZERO;
        mf_view[irq_flags_pkg::MF0_FLAG_BIT] = q.mf_flag[0];
        mf_view[irq_flags_pkg::MF1_FLAG_BIT] = q.mf_flag[1];
        mf_view[irq_flags_pkg::MF0_EN_BIT] = q.mf_en[0];
        mf_view[irq_flags_pkg::MF1_EN_BIT] = q.mf_en[1];
    end

    // Status and mask sit in the low nibble
    assign status_view = {4'h0, ev_status};
    assign mask_view = {4'h0, ev_mask};

    // ************************************************************
    // Next state
    // ************************************************************
    // Multi-function flags: hardware set beats a software clear,
    // so a request landing in the clearing cycle is kept.
    // Limitation: the flag re-sets while a timer request stands, so
    // software must clear the timer flag before this one.
    always_comb begin
        d = q;
        if (mf_wr) begin
            d.mf_flag[0] = wdata_i[irq_flags_pkg::MF0_FLAG_BIT];
            d.mf_flag[1] = wdata_i[irq_flags_pkg::MF1_FLAG_BIT];
            d.mf_en[0] = wdata_i[irq_flags_pkg::MF0_EN_BIT];
            d.mf_en[1] = wdata_i[irq_flags_pkg::MF1_EN_BIT];
        end
        for (int i = 0; i < 2; i++) begin
            if (timer_req[i]) begin
                d.mf_flag[i] = 1'b1;
            end
        end
        // Gated request to the core; one cycle behind the flag
        d.mf_req = q.mf_flag & q.mf_en;
        d.irq = ev_irq;
        // Read data stands only in the cycle after the strobe
        d.rdata = irq_flags_pkg::READ_ZERO;
        if (rd_i) begin
            unique case (addr_i)
                irq_flags_pkg::TIMER0_CTRL_ADDR: begin
                    d.rdata = timer_rdata[0] & irq_flags_pkg::TIMER_IMPL_MASK;
                end
                irq_flags_pkg::TIMER1_CTRL_ADDR: begin
                    d.rdata = timer_rdata[1] & irq_flags_pkg::TIMER_IMPL_MASK;
                end
                irq_flags_pkg::MULTIFUNC_CTRL_ADDR: begin
                    d.rdata = mf_view & irq_flags_pkg::MULTIFUNC_IMPL_MASK;
                end
                irq_flags_pkg::EVENT_STATUS_ADDR: begin
                    d.rdata = status_view & irq_flags_pkg::EVENT_IMPL_MASK;
                end
                irq_flags_pkg::EVENT_MASK_ADDR: begin
                    d.rdata = mask_view & irq_flags_pkg::EVENT_IMPL_MASK;
                end
                default: begin
                    // Unmapped addresses answer zero
                    d.rdata = irq_flags_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_o = q.rdata;
    assign multifunc0_request_o = q.mf_req[0];
    assign multifunc1_request_o = q.mf_req[1];
    assign irq_o = q.irq;

    // ************************************************************
    // Assertions
    // ************************************************************
    // All checks run on the system clock and rest while reset is low
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // A timer 0 comparator A match shows as a set flag next cycle
    t0_a_flag_a: assert property (
        t0_cmp_a_match_i |=> timer_rdata[0][irq_flags_pkg::CMP_A_FLAG_BIT]
    ) else $error("timer 0 A flag not set after match");

    // A timer 0 comparator P match shows as a set flag next cycle
    t0_p_flag_a: assert property (
        t0_cmp_p_match_i |=> timer_rdata[0][irq_flags_pkg::CMP_P_FLAG_BIT]
    ) else $error("timer 0 P flag not set after match");

    // Enabled timer 0 A flag drives the timer 0 request
    t0_a_enable_a: assert property (
        timer_rdata[0][irq_flags_pkg::CMP_A_FLAG_BIT] && timer_rdata[0][irq_flags_pkg::CMP_A_EN_BIT]
            |-> timer_req[0]
    ) else $error("enabled timer 0 A flag gives no request");

    // A timer 1 comparator A match survives even a clearing write
    t1_a_flag_a: assert property (
        t1_cmp_a_match_i && timer_wr[1] |=> timer_rdata[1][irq_flags_pkg::CMP_A_FLAG_BIT]
    ) else $error("timer 1 A match lost against a write");

    // A timer 1 comparator P match, then read it back two cycles on
    t1_p_flag_a: assert property (
        t1_cmp_p_match_i ##1 (rd_i && addr_i == irq_flags_pkg::TIMER1_CTRL_ADDR && !wr_i)
            |=> rdata_o[irq_flags_pkg::CMP_P_FLAG_BIT]
    ) else $error("timer 1 P flag not seen on readback");

    // With both timer 1 enables off no request leaves the timer
    t1_enable_a: assert property (
        !timer_rdata[1][irq_flags_pkg::CMP_A_EN_BIT] && !timer_rdata[1][irq_flags_pkg::CMP_P_EN_BIT]
            |-> !timer_req[1]
    ) else $error("disabled timer 1 still requests");

    // Unused bit pairs of a timer register read zero
    unused_bits_a: assert property (
        rd_i && (addr_i == irq_flags_pkg::TIMER0_CTRL_ADDR || addr_i == irq_flags_pkg::TIMER1_CTRL_ADDR)
            |=> (rdata_o & ~irq_flags_pkg::TIMER_IMPL_MASK) == irq_flags_pkg::READ_ZERO
    ) else $error("unused timer bits read non-zero");

    // Request reaches the multi-function 0 pin within two cycles
    mf0_request_a: assert property (
        timer_req[0] && q.mf_en[0] && !mf_wr |-> ##2 multifunc0_request_o
    ) else $error("multi-function 0 request missing");

    // Timer 1 request always lands in the multi-function 1 flag
    mf_flag_set_a: assert property (
        timer_req[1] |=> q.mf_flag[1]
    ) else $error("multi-function 1 flag not set");

    // Read data stands for one cycle only
    read_once_a: assert property (
        !rd_i |=> rdata_o == irq_flags_pkg::READ_ZERO
    ) else $error("read data outside the answer cycle");

    // Interrupt follows unmasked status one cycle later
    irq_level_a: assert property (
        |(ev_status & ev_mask) |=> irq_o
    ) else $error("interrupt missing for unmasked status");

    // Interrupt drops once all status clears by read
    irq_drop_a: assert property (
        status_rd && !(|{t1_cmp_p_match_i, t1_cmp_a_match_i, t0_cmp_p_match_i, t0_cmp_a_match_i})
            |=> ##1 !irq_o
    ) else $error("interrupt held after status read");

    // A timer 1 comparator P match shows as a set flag next cycle
    t1_p_set_a: assert property (
        t1_cmp_p_match_i |=> timer_rdata[1][irq_flags_pkg::CMP_P_FLAG_BIT]
    ) else $error("timer 1 P flag not set after match");

    // A timer 0 comparator P match outlives a clearing write
    t0_p_keep_a: assert property (
        t0_cmp_p_match_i && timer_wr[0] |=> timer_rdata[0][irq_flags_pkg::CMP_P_FLAG_BIT]
    ) else $error("timer 0 P match lost against a write");

    // Enabled timer 1 A flag drives the timer 1 request
    t1_a_enable_a: assert property (
        timer_rdata[1][irq_flags_pkg::CMP_A_FLAG_BIT] && timer_rdata[1][irq_flags_pkg::CMP_A_EN_BIT]
            |-> timer_req[1]
    ) else $error("enabled timer 1 A flag gives no request");

    // With both timer 0 enables off no request leaves the timer
    t0_disable_a: assert property (
        !timer_rdata[0][irq_flags_pkg::CMP_A_EN_BIT] && !timer_rdata[0][irq_flags_pkg::CMP_P_EN_BIT]
            |-> !timer_req[0]
    ) else $error("disabled timer 0 still requests");

    // Timer 0 request always lands in the multi-function 0 flag
    mf0_flag_set_a: assert property (
        timer_req[0] |=> q.mf_flag[0]
    ) else $error("multi-function 0 flag not set");

    // Request reaches the multi-function 1 pin within two cycles
    mf1_request_a: assert property (
        timer_req[1] && q.mf_en[1] && !mf_wr |-> ##2 multifunc1_request_o
    ) else $error("multi-function 1 request missing");

    // A write to the multi-function register loads the mf0 enable
    mf0_enable_a: assert property (
        mf_wr |=> q.mf_en[0] == $past(wdata_i[irq_flags_pkg::MF0_EN_BIT])
    ) else $error("multi-function 0 enable not loaded");

    // No mf0 request leaves without both flag and enable
    mf0_quiet_a: assert property (
        !(q.mf_flag[0] && q.mf_en[0]) |=> !multifunc0_request_o
    ) else $error("multi-function 0 request without cause");

    // A timer 1 comparator P match sets its sticky status bit, read or not
    status_set_a: assert property (
        t1_cmp_p_match_i |=> ev_status[3]
    ) else $error("status bit not set after match");

    // Status stays set until a read of the status register
    status_hold_a: assert property (
        ev_status[0] && !status_rd |=> ev_status[0]
    ) else $error("status bit lost without a read");

    // No unmasked status means no interrupt one cycle later
    irq_quiet_a: assert property (
        !(|(ev_status & ev_mask)) |=> !irq_o
    ) else $error("interrupt without unmasked status");

    // ************************************************************
    // Coverage of main scenarios
    // ************************************************************
    match_clear_c: cover property (
        t0_cmp_a_match_i && timer_wr[0] && !wdata_i[irq_flags_pkg::CMP_A_FLAG_BIT]
    );
    mf0_raise_c: cover property (
        $rose(multifunc0_request_o)
    );
    status_read_c: cover property (
        irq_o ##1 status_rd ##2 !irq_o
    );
    both_timers_c: cover property (
        timer_req[0] && timer_req[1]
    );
    p_only_c: cover property (
        timer_req[0] && !timer_rdata[0][irq_flags_pkg::CMP_A_EN_BIT]
    );

endmodule // timer_match_irq_flags

// ==== hw/timer_match_regs.sv ====
// One timer's match register: two sticky request flags and two enables.
// Assumes one-cycle match pulses synchronous to clk_i.
`timescale 1ns/1ps
module timer_match_regs (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wdata_i,
    input wire logic cmp_a_match_i,
    input wire logic cmp_p_match_i,
    output logic [7:0] rdata_o,
    output logic request_o
);

    typedef struct packed {
        logic a_flag;
        logic p_flag;
        logic a_en;
        logic p_en;
    } state_type;

    state_type q;
    state_type d;

    // ************************************************************
    // Next state: software write, then hardware set on top
    // ************************************************************
    always_comb begin
        d = q;
        if (wr_en_i) begin
            d.a_flag = wdata_i[irq_flags_pkg::CMP_A_FLAG_BIT];
            d.p_flag = wdata_i[irq_flags_pkg::CMP_P_FLAG_BIT];
            d.a_en = wdata_i[irq_flags_pkg::CMP_A_EN_BIT];
            d.p_en = wdata_i[irq_flags_pkg::CMP_P_EN_BIT];
        end
        // Set wins so a match in the clearing cycle is not lost
        if (cmp_a_match_i) begin
            d.a_flag = 1'b1;
        end
        if (cmp_p_match_i) begin
            d.p_flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Read view; unused pairs read as zero
    always_comb begin
        rdata_o = irq_flags_pkg::READ_ZERO;
        rdata_o[irq_flags_pkg::CMP_A_FLAG_BIT] = q.a_flag;
        rdata_o[irq_flags_pkg::CMP_P_FLAG_BIT] = q.p_flag;
        rdata_o[irq_flags_pkg::CMP_A_EN_BIT] = q.a_en;
        rdata_o[irq_flags_pkg::CMP_P_EN_BIT] = q.p_en;
    end

    // Request toward the multi-function flag
    assign request_o = (q.a_flag & q.a_en) | (q.p_flag & q.p_en);

endmodule // timer_match_regs

// ==== verification/timer_cmp_model.sv ====
// Behavioural model of the two timer modules' comparators on the event side.
// Assumes the bench asks for matches on fire_i; each request becomes one pulse.
`timescale 1ns/1ps
module timer_cmp_model (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] fire_i,
    output logic [3:0] match_o
);
    // ************************************************************
    // Match pulse generation
    // ************************************************************
    logic [3:0] match_q;
    logic [3:0] match_d;

    // Order is t0 A, t0 P, t1 A, t1 P; low between requests, never left floating
    assign match_d = fire_i;
    assign match_o = match_q;

    // Registered so pulses launch just after a clock edge, like real comparators
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            match_q <= 4'h0;
        end else begin
            match_q <= match_d;
        end
    end
endmodule // timer_cmp_model

// ==== verification/timer_match_irq_flags_test.sv ====
// Self-checking bench for the timer match interrupt flags: register tasks and scenarios.
// Assumes the comparator model drives the match inputs and the design sits under hw/.
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module timer_match_irq_flags_test;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic clk_i;
    logic reset_n_i;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_rdata;
    logic [3:0] fire;
    logic [3:0] match;
    logic [1:0] mf_req;
    logic irq;
    logic [7:0] ta;
    logic [7:0] en;
    int num_errors = 0;
    int compares = 0;

    timer_cmp_model model (.clk_i(clk_i), .reset_n_i(reset_n_i), .fire_i(fire), .match_o(match));

    timer_match_irq_flags dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(bus_addr), .wdata_i(bus_wdata),
        .wr_i(bus_wr), .rd_i(bus_rd), .rdata_o(bus_rdata), .t0_cmp_a_match_i(match[0]),
        .t0_cmp_p_match_i(match[1]), .t1_cmp_a_match_i(match[2]), .t1_cmp_p_match_i(match[3]),
        .multifunc0_request_o(mf_req[0]), .multifunc1_request_o(mf_req[1]), .irq_o(irq));

    // 40 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ************************************************************
    // Helpers and bus tasks
    // ************************************************************
    function automatic logic [7:0] bitv(input int unsigned b);
        return 8'h01 << b;
    endfunction

    // Strobe is dropped one edge later, so back-to-back calls leave a gap cycle
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_i);
        bus_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        @(posedge clk_i);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_i);
        bus_rd <= 1'b0;
        #1;
        v = bus_rdata;
        `CHECK(v, exp)
    endtask

    // Enough cycles for flag, multi-function flag and request output to settle
    task automatic settle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    task automatic fire_event(input logic [3:0] m);
        @(posedge clk_i);
        fire <= m;
        @(posedge clk_i);
        fire <= 4'h0;
        settle();
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        #500000;
        num_errors++;
        give_verdict();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        reset_n_i = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        fire = 4'h0;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        `CHECK(mf_req, 2'b00)
        // Reset values, unmapped address included
        for (int a = 0; a < 6; a++) begin
            check_reg(8'(a), irq_flags_pkg::REG_RESET);
        end
        en = bitv(irq_flags_pkg::MF0_EN_BIT) | bitv(irq_flags_pkg::MF1_EN_BIT);
        // Unused bit pairs ignore writes and read zero
        for (int t = 0; t < 2; t++) begin
            ta = (t == 0) ? irq_flags_pkg::TIMER0_CTRL_ADDR : irq_flags_pkg::TIMER1_CTRL_ADDR;
            write_reg(ta, 8'hff);
            check_reg(ta, irq_flags_pkg::TIMER_IMPL_MASK);
            write_reg(ta, 8'h00);
            check_reg(ta, 8'h00);
        end
        write_reg(irq_flags_pkg::MULTIFUNC_CTRL_ADDR, en);
        write_reg(irq_flags_pkg::EVENT_MASK_ADDR, 8'h0f);
        check_reg(irq_flags_pkg::EVENT_STATUS_ADDR, 8'h00);
        for (int t = 0; t < 2; t++) begin
            ta = (t == 0) ? irq_flags_pkg::TIMER0_CTRL_ADDR : irq_flags_pkg::TIMER1_CTRL_ADDR;
            // Enabled comparator A match reaches the request and the interrupt
            write_reg(ta, bitv(irq_flags_pkg::CMP_A_EN_BIT));
            fire_event(4'h1 << (2 * t));
            `CHECK(mf_req[t], 1'b1)
            `CHECK(irq, 1'b1)
            check_reg(ta, bitv(irq_flags_pkg::CMP_A_FLAG_BIT) | bitv(irq_flags_pkg::CMP_A_EN_BIT));
            check_reg(irq_flags_pkg::MULTIFUNC_CTRL_ADDR,
                en | bitv((t == 0) ? irq_flags_pkg::MF0_FLAG_BIT : irq_flags_pkg::MF1_FLAG_BIT));
            check_reg(irq_flags_pkg::EVENT_STATUS_ADDR, bitv(2 * t));
            check_reg(irq_flags_pkg::EVENT_STATUS_ADDR, 8'h00);
            settle();
            `CHECK(irq, 1'b0)
            // Timer flag must go before the multi-function flag, else it re-sets
            write_reg(ta, 8'h00);
            write_reg(irq_flags_pkg::MULTIFUNC_CTRL_ADDR, en);
            write_reg(irq_flags_pkg::EVENT_MASK_ADDR, 8'h00);
            settle();
            `CHECK(mf_req[t], 1'b0)
            // Both comparators with enables off: flags set, no request, masked irq
            fire_event(4'h3 << (2 * t));
            `CHECK(mf_req[t], 1'b0)
            `CHECK(irq, 1'b0)
            check_reg(ta, bitv(irq_flags_pkg::CMP_A_FLAG_BIT) | bitv(irq_flags_pkg::CMP_P_FLAG_BIT));
            check_reg(irq_flags_pkg::MULTIFUNC_CTRL_ADDR, en);
            check_reg(irq_flags_pkg::EVENT_STATUS_ADDR, 8'h03 << (2 * t));
            // P enable gates the P flag into the request as well
            write_reg(ta, bitv(irq_flags_pkg::CMP_P_FLAG_BIT) | bitv(irq_flags_pkg::CMP_P_EN_BIT));
            settle();
            `CHECK(mf_req[t], 1'b1)
            write_reg(ta, 8'h00);
            write_reg(irq_flags_pkg::MULTIFUNC_CTRL_ADDR, en);
            settle();
            `CHECK(mf_req[t], 1'b0)
            // Enabling comparator A alone now raises the request
            write_reg(ta, bitv(irq_flags_pkg::CMP_A_FLAG_BIT) | bitv(irq_flags_pkg::CMP_A_EN_BIT));
            settle();
            `CHECK(mf_req[t], 1'b1)
            write_reg(ta, 8'h00);
            write_reg(irq_flags_pkg::MULTIFUNC_CTRL_ADDR, en);
            write_reg(irq_flags_pkg::EVENT_MASK_ADDR, 8'h0f);
            settle();
            `CHECK(mf_req, 2'b00)
        end
        // A match landing in the same cycle as a clearing write keeps its flag
        @(posedge clk_i);
        fire <= 4'h1;
        @(posedge clk_i);
        fire <= 4'h0;
        bus_addr <= irq_flags_pkg::TIMER0_CTRL_ADDR;
        bus_wdata <= 8'h00;
        bus_wr <= 1'b1;
        @(posedge clk_i);
        bus_wr <= 1'b0;
        check_reg(irq_flags_pkg::TIMER0_CTRL_ADDR, bitv(irq_flags_pkg::CMP_A_FLAG_BIT));
        check_reg(irq_flags_pkg::EVENT_STATUS_ADDR, 8'h01);
        give_verdict();
    end
endmodule // timer_match_irq_flags_test
